// ===== design/pllsw_mon.sv
// Module: stopped-clock detector for one sampled reference clock
`timescale 1ns/1ps
module pllsw_mon
  import pllsw_pkg::*;
#(
  parameter int TIMEOUT = FAULT_CYC
)(
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  pllsw_mon_if.mon  mon
);

  localparam int CW = $clog2(TIMEOUT + 1);

  // Refused while elaborating: a shorter timeout would flag a healthy clock
  if (TIMEOUT < 2)
  begin : g_bad_timeout
    $error("pllsw_mon: TIMEOUT must be at least 2");
  end

  logic          ref_q_r;
  logic [CW-1:0] idle_cnt_r;
  logic          toggle;

  assign toggle = mon.ref_clk != ref_q_r;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ref_q_r  <= 1'b0;
      mon.rise <= 1'b0;
    end
    else
    begin
      ref_q_r  <= mon.ref_clk;
      mon.rise <= mon.ref_clk & ~ref_q_r;
    end
  end

  // A quiet reference is flagged after TIMEOUT + 1 cycles without any edge
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      idle_cnt_r <= '0;
      mon.fault  <= 1'b0;
    end
    else if (!mon.enable || toggle)
    begin
      idle_cnt_r <= '0;
      mon.fault  <= 1'b0;
    end
    else if (idle_cnt_r == CW'(TIMEOUT))
      mon.fault  <= 1'b1;
    else
      idle_cnt_r <= idle_cnt_r + CW'(1);
  end

endmodule : pllsw_mon

// ===== design/pllsw_mon_if.sv
// Interface: one reference clock activity monitor and its consumer
`timescale 1ns/1ps
interface pllsw_mon_if;
  logic ref_clk;
  logic enable;
  logic rise;
  logic fault;
  modport mon (input ref_clk, input enable, output rise, output fault);
  modport ctl (output ref_clk, output enable, input rise, input fault);
endinterface : pllsw_mon_if

// ===== design/pllsw_pkg.sv
// Package: register map, field layout, reset values and timing counts of the switchover block
package pllsw_pkg;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [7:0] PLLSW_CTRL_OFS   = 8'h00;
  localparam logic [7:0] PLLSW_DELAY_OFS  = 8'h04;
  localparam logic [7:0] PLLSW_STATUS_OFS = 8'h08;
  localparam logic [7:0] PLLSW_ISTAT_OFS  = 8'h0C;
  localparam logic [7:0] PLLSW_IMASK_OFS  = 8'h10;

  // ****************************************
  // Control fields
  // ****************************************
  localparam int CTRL_SEC_EN_BIT   = 0;
  localparam int CTRL_MODE_LSB     = 1;
  localparam int CTRL_DELAY_EN_BIT = 3;
  localparam int CTRL_PHASE_EN_BIT = 4;
  localparam int CTRL_RES_LSB      = 8;
  localparam int CTRL_RES_W        = 8;
  localparam logic [31:0] CTRL_RST = 32'h0000_0100;
  localparam logic [15:0] DELAY_RST = 16'h0000;

  // ****************************************
  // Status fields and interrupt bits
  // ****************************************
  localparam int STAT_ACTIVE_BIT = 0;
  localparam int STAT_PFAULT_BIT = 1;
  localparam int STAT_SFAULT_BIT = 2;
  localparam int STAT_BUSY_BIT   = 3;
  localparam int STAT_LOCK_BIT   = 4;
  localparam int STAT_PHASE_LSB  = 8;
  localparam int IRQ_W           = 4;
  localparam int IRQ_SWITCH_BIT  = 0;
  localparam int IRQ_PFAULT_BIT  = 1;
  localparam int IRQ_SFAULT_BIT  = 2;
  localparam int IRQ_PDONE_BIT   = 3;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS    = 20;
  localparam int FAULT_TIME_NS    = 320;
  localparam int FAULT_CYC        = (FAULT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PHASE_SCAN_EDGES = 2;

  typedef enum logic [1:0] {PLLSW_MANUAL, PLLSW_AUTO, PLLSW_AUTO_OVR} pllsw_mode_t;
  typedef enum logic {PLLSW_IDLE, PLLSW_WAIT} pllsw_state_t;

endpackage : pllsw_pkg

// ===== design/pllsw_top.sv
// Module: reference clock switchover, fault report and phase step control with APB registers
//
// Decided for this implementation: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module pllsw_top
  import pllsw_pkg::*;
#(
  parameter int NUM_CNT   = 8,
  parameter int DELAY_W   = 16,
  parameter int PHASE_W   = 8,
  parameter int TIMEOUT   = FAULT_CYC
)(
  input  wire logic                       clk_i,
  input  wire logic                       rst_n_i,
  input  wire logic                       psel_i,
  input  wire logic                       penable_i,
  input  wire logic                       pwrite_i,
  input  wire logic [7:0]                 paddr_i,
  input  wire logic [31:0]                pwdata_i,
  output logic      [31:0]                prdata_o,
  output logic                            pready_o,
  output logic                            pslverr_o,
  input  wire logic                       primary_ref_clock_i,
  input  wire logic                       secondary_ref_clock_i,
  input  wire logic                       pll_locked_i,
  input  wire logic                       switch_req_i,
  output logic                            active_ref_o,
  output logic                            primary_ref_fault_o,
  output logic                            secondary_ref_fault_o,
  input  wire logic [$clog2(NUM_CNT)-1:0] phase_cnt_sel_i,
  input  wire logic                       phase_up_dn_i,
  input  wire logic                       phase_step_i,
  input  wire logic                       scan_clk_i,
  output logic                            phase_done_o,
  output logic                            irq_o
);

  localparam int SW = $clog2(NUM_CNT);

  // Counter select must index every phase word; fields must fit their register slots
  if (NUM_CNT < 2 || (NUM_CNT & (NUM_CNT - 1)) != 0 || DELAY_W < 1 || DELAY_W > 16 || PHASE_W < 4 || PHASE_W > 8)
  begin : g_bad_params
    $error("pllsw_top: unsupported parameter values");
  end

  // ****************************************
  // Registers and monitors
  // ****************************************
  logic [31:0]        ctrl_r;
  logic [DELAY_W-1:0] delay_r;
  logic [IRQ_W-1:0]   istat_r;
  logic [IRQ_W-1:0]   imask_r;
  logic [IRQ_W-1:0]   ievt;
  pllsw_state_t       state_r;
  logic [DELAY_W-1:0] wait_cnt_r;
  logic               active_r;
  logic               locked_q_r;
  logic               req_q_r;
  logic               pfault_q_r;
  logic               sfault_q_r;
  logic               sw_evt_r;
  logic               trigger;
  logic               fire_now;
  logic               wr_en;
  logic               sec_en;
  logic               delay_en;
  pllsw_mode_t        mode;

  assign sec_en   = ctrl_r[CTRL_SEC_EN_BIT];
  assign delay_en = ctrl_r[CTRL_DELAY_EN_BIT];
  assign mode     = pllsw_mode_t'(ctrl_r[CTRL_MODE_LSB +: 2]);
  assign wr_en    = psel_i & penable_i & pwrite_i;

  pllsw_mon_if pmon ();
  pllsw_mon_if smon ();

  assign pmon.ref_clk = primary_ref_clock_i;
  assign pmon.enable  = 1'b1;
  assign smon.ref_clk = secondary_ref_clock_i;
  assign smon.enable  = sec_en;

  pllsw_mon #(.TIMEOUT(TIMEOUT)) u_pmon (.clk_i(clk_i), .rst_n_i(rst_n_i), .mon(pmon));
  pllsw_mon #(.TIMEOUT(TIMEOUT)) u_smon (.clk_i(clk_i), .rst_n_i(rst_n_i), .mon(smon));

  // ****************************************
  // Switchover control
  // ****************************************
  always_comb
  begin
    trigger = 1'b0;
    if (sec_en && state_r == PLLSW_IDLE)
    begin
      case (mode)
        PLLSW_MANUAL:   trigger = switch_req_i != active_r;
        PLLSW_AUTO:     trigger = (locked_q_r & ~pll_locked_i) | (~active_r & pmon.fault);
        PLLSW_AUTO_OVR: trigger = (locked_q_r & ~pll_locked_i) | (switch_req_i & ~req_q_r);
        default:        trigger = 1'b0;
      endcase
    end
  end

  // Delay counts rising edges of the reference being switched to, so a dead outgoing source cannot stall it
  assign fire_now = trigger & ~(delay_en & (delay_r != '0));

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_r    <= PLLSW_IDLE;
      wait_cnt_r <= '0;
      active_r   <= 1'b0;
      sw_evt_r   <= 1'b0;
    end
    else
    begin
      sw_evt_r <= 1'b0;
      if (!sec_en)
      begin
        state_r  <= PLLSW_IDLE;
        active_r <= 1'b0;
      end
      else
      begin
        case (state_r)
          PLLSW_IDLE:
          begin
            if (fire_now)
            begin
              active_r <= ~active_r;
              sw_evt_r <= 1'b1;
            end
            else if (trigger)
            begin
              state_r    <= PLLSW_WAIT;
              wait_cnt_r <= delay_r;
            end
          end
          PLLSW_WAIT:
          begin
            if (active_r ? pmon.rise : smon.rise)
            begin
              if (wait_cnt_r == DELAY_W'(1))
              begin
                state_r  <= PLLSW_IDLE;
                active_r <= ~active_r;
                sw_evt_r <= 1'b1;
              end
              wait_cnt_r <= wait_cnt_r - DELAY_W'(1);
            end
          end
          default: state_r <= PLLSW_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      locked_q_r            <= 1'b0;
      req_q_r               <= 1'b0;
      pfault_q_r            <= 1'b0;
      sfault_q_r            <= 1'b0;
      active_ref_o          <= 1'b0;
      primary_ref_fault_o   <= 1'b0;
      secondary_ref_fault_o <= 1'b0;
    end
    else
    begin
      locked_q_r            <= pll_locked_i;
      req_q_r               <= switch_req_i;
      pfault_q_r            <= pmon.fault;
      sfault_q_r            <= smon.fault;
      active_ref_o          <= active_r;
      primary_ref_fault_o   <= pmon.fault;
      secondary_ref_fault_o <= smon.fault;
    end
  end

  // ****************************************
  // Dynamic phase stepping
  // ****************************************
  // Scan clock is sampled, so it must run well below half the bus clock
  logic               phase_en;
  logic               step_q_r;
  logic               scan_q_r;
  logic               busy_r;
  logic               pdone_evt_r;
  logic [SW-1:0]      sel_r;
  logic               dir_r;
  logic [1:0]         scan_cnt_r;
  logic [PHASE_W-1:0] phase_r [NUM_CNT];
  logic [PHASE_W-1:0] res;
  logic               step_take;

  assign phase_en  = ctrl_r[CTRL_PHASE_EN_BIT];
  assign res       = ctrl_r[CTRL_RES_LSB +: PHASE_W];
  assign step_take = phase_en & phase_step_i & ~step_q_r & ~busy_r;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      step_q_r    <= 1'b0;
      scan_q_r    <= 1'b0;
      busy_r      <= 1'b0;
      pdone_evt_r <= 1'b0;
      sel_r       <= '0;
      dir_r       <= 1'b0;
      scan_cnt_r  <= '0;
      for (int i = 0; i < NUM_CNT; i++)
        phase_r[i] <= '0;
    end
    else
    begin
      step_q_r    <= phase_step_i;
      scan_q_r    <= scan_clk_i;
      pdone_evt_r <= 1'b0;
      if (step_take)
      begin
        busy_r     <= 1'b1;
        sel_r      <= phase_cnt_sel_i;
        dir_r      <= phase_up_dn_i;
        scan_cnt_r <= '0;
      end
      else if (busy_r && scan_clk_i && !scan_q_r)
      begin
        scan_cnt_r <= scan_cnt_r + 2'h1;
        if (scan_cnt_r == 2'(PHASE_SCAN_EDGES - 1))
        begin
          // Each unit is one eighth of the oscillator period; res sets units per step
          phase_r[sel_r] <= dir_r ? phase_r[sel_r] + res : phase_r[sel_r] - res;
          busy_r         <= 1'b0;
          pdone_evt_r    <= 1'b1;
        end
      end
    end
  end

  assign phase_done_o = ~busy_r;

  // ****************************************
  // APB slave and interrupts
  // ****************************************
  assign ievt[IRQ_SWITCH_BIT] = sw_evt_r;
  assign ievt[IRQ_PFAULT_BIT] = pmon.fault & ~pfault_q_r;
  assign ievt[IRQ_SFAULT_BIT] = smon.fault & ~sfault_q_r;
  assign ievt[IRQ_PDONE_BIT]  = pdone_evt_r;

  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i & penable_i & ~(paddr_i == PLLSW_CTRL_OFS || paddr_i == PLLSW_DELAY_OFS
                     || paddr_i == PLLSW_STATUS_OFS || paddr_i == PLLSW_ISTAT_OFS || paddr_i == PLLSW_IMASK_OFS);

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ctrl_r  <= CTRL_RST;
      delay_r <= DELAY_RST[DELAY_W-1:0];
      imask_r <= '0;
    end
    else if (wr_en)
    begin
      if (paddr_i == PLLSW_CTRL_OFS)
        ctrl_r <= pwdata_i;
      else if (paddr_i == PLLSW_DELAY_OFS)
        delay_r <= pwdata_i[DELAY_W-1:0];
      else if (paddr_i == PLLSW_IMASK_OFS)
        imask_r <= pwdata_i[IRQ_W-1:0];
    end
  end

  // New events win over a same-cycle write-one-to-clear
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      istat_r <= '0;
    else if (wr_en && paddr_i == PLLSW_ISTAT_OFS)
      istat_r <= (istat_r & ~pwdata_i[IRQ_W-1:0]) | ievt;
    else
      istat_r <= istat_r | ievt;
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      irq_o <= 1'b0;
    else
      irq_o <= |(istat_r & imask_r);
  end

  always_comb
  begin
    prdata_o = 32'h0000_0000;
    if (psel_i && !pwrite_i)
    begin
      if (paddr_i == PLLSW_CTRL_OFS)
        prdata_o = ctrl_r;
      else if (paddr_i == PLLSW_DELAY_OFS)
        prdata_o = 32'(delay_r);
      else if (paddr_i == PLLSW_STATUS_OFS)
      begin
        prdata_o[STAT_ACTIVE_BIT] = active_r;
        prdata_o[STAT_PFAULT_BIT] = pmon.fault;
        prdata_o[STAT_SFAULT_BIT] = smon.fault;
        prdata_o[STAT_BUSY_BIT]   = busy_r;
        prdata_o[STAT_LOCK_BIT]   = pll_locked_i;
        prdata_o[STAT_PHASE_LSB +: PHASE_W] = phase_r[sel_r];
      end
      else if (paddr_i == PLLSW_ISTAT_OFS)
        prdata_o = 32'(istat_r);
      else if (paddr_i == PLLSW_IMASK_OFS)
        prdata_o = 32'(imask_r);
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  AST_SEC_DISABLED: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !sec_en |=> !active_r) else $error("secondary selected while disabled");
  AST_PRIMARY_AT_RESET: assert property (@(posedge clk_i)
    !rst_n_i |=> !active_r) else $error("primary not selected after reset");
  AST_MANUAL_FOLLOW: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (mode == PLLSW_MANUAL && fire_now && sec_en) |=> active_r == $past(switch_req_i))
    else $error("manual selection not followed");
  AST_AUTO_FAULT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (sec_en && mode == PLLSW_AUTO && state_r == PLLSW_IDLE && !active_r && pmon.fault && !delay_en)
    |=> active_r ##1 active_ref_o) else $error("no switch on primary fault");
  AST_OVERRIDE_REQ: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (sec_en && mode == PLLSW_AUTO_OVR && state_r == PLLSW_IDLE && $rose(switch_req_i) && !delay_en)
    |=> active_r != $past(active_r)) else $error("override request ignored");
  AST_DELAY_HOLDS: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (trigger && !fire_now && sec_en) |=> state_r == PLLSW_WAIT && $stable(active_r))
    else $error("switch not delayed");
  AST_ACTIVE_OUT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $changed(active_ref_o) |-> $past(sw_evt_r, 1) || $past(!sec_en, 2))
    else $error("active output changed without switchover");
  AST_PFAULT_CLEARS: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $changed(primary_ref_clock_i) |-> ##[1:2] !primary_ref_fault_o)
    else $error("primary fault while toggling");
  AST_SFAULT_CLEARS: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $changed(secondary_ref_clock_i) |-> ##[1:2] !secondary_ref_fault_o)
    else $error("secondary fault while toggling");
  AST_STEP_BUSY: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    step_take |=> !phase_done_o && sel_r == $past(phase_cnt_sel_i))
    else $error("phase step not taken");

endmodule : pllsw_top

// ===== sim/pll_ref_clock_switchover_tb.sv
// Testbench: APB register, switchover, fault and phase step checks
`timescale 1ns/1ps
module pll_ref_clock_switchover_tb;
  import pllsw_pkg::*;
  localparam int TMO  = 8;
  localparam int HALF = 3;
  logic        clk_i, rst_n_i, psel, penable, pwrite, locked, swreq, up_dn, pstep, scan;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, seed, q;
  logic        pready, pslverr, run_p, run_s, pclk, sclk, act, pf, sf, pdone, irq, e;
  logic [2:0]  sel;
  int          miscompares, n_checks, n;
  logic [7:0]  r1, r2;
  wire  [4:0]  obs = {irq, pdone, sf, pf, act};

  pllsw_top #(.TIMEOUT(TMO)) dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .primary_ref_clock_i(pclk), .secondary_ref_clock_i(sclk), .pll_locked_i(locked),
    .switch_req_i(swreq), .active_ref_o(act), .primary_ref_fault_o(pf), .secondary_ref_fault_o(sf),
    .phase_cnt_sel_i(sel), .phase_up_dn_i(up_dn), .phase_step_i(pstep), .scan_clk_i(scan),
    .phase_done_o(pdone), .irq_o(irq));
  pllsw_ref_src #(.HALF(HALF)) src (.clk_i(clk_i), .run_p_i(run_p), .run_s_i(run_s),
    .primary_ref_clock_o(pclk), .secondary_ref_clock_o(sclk));

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : complete_run

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk32

  task automatic chk1(input logic got, input logic exp);
    chk32({31'h0, got}, {31'h0, exp});
  endtask : chk1

  task automatic cyc(input int k);
    repeat (k) @(negedge clk_i);
  endtask : cyc

  // Bounded wait on one output bit, sampled mid-cycle
  task automatic wait_obs(input int idx, input logic v, input int k);
    for (int i = 0; i < k && obs[idx] !== v; i++)
      @(negedge clk_i);
    chk1(obs[idx], v);
  endtask : wait_obs

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    do @(posedge clk_i); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk32(q, exp);
  endtask : rd

  task automatic phase_run(input logic [7:0] res, input logic dir, input logic [7:0] exp);
    wr(PLLSW_CTRL_OFS, {16'h0, res, 8'h10});
    @(posedge clk_i);
    up_dn <= dir;
    pstep <= 1'b1;
    @(posedge clk_i) pstep <= 1'b0;
    cyc(2);
    chk1(pdone, 1'b0);
    repeat (4)
    begin
      @(posedge clk_i) scan <= ~scan;
      @(posedge clk_i);
    end
    wait_obs(3, 1'b1, 8);
    rd(PLLSW_STATUS_OFS, {16'h0, exp, 8'h10});
  endtask : phase_run

  // ****************************************
  // Clock, watchdog and sequence
  // ****************************************
  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // Whole sequence needs a few hundred cycles; the margin is generous
  initial
  begin
    #(20 * 60000);
    miscompares++;
    complete_run();
  end

  initial
  begin
    miscompares = 0;
    n_checks = 0;
    seed = 32'h7542;
    {rst_n_i, psel, penable, pwrite, swreq, up_dn, pstep, scan} = 8'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    {locked, run_p, run_s} = 3'b111;
    seed = lfsr(seed);
    sel = seed[2:0];
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rd(PLLSW_CTRL_OFS, CTRL_RST);
    rd(PLLSW_DELAY_OFS, 32'h0);
    rd(PLLSW_ISTAT_OFS, 32'h0);
    rd(PLLSW_IMASK_OFS, 32'h0);
    rd(PLLSW_STATUS_OFS, 32'h10);
    chk1(pdone, 1'b1);
    apb(1'b0, 8'h14, 32'h0);
    chk32(q, 32'h0);
    chk1(e, 1'b1);
    @(posedge clk_i) swreq <= 1'b1;
    cyc(10);
    chk1(act, 1'b0);
    wr(PLLSW_CTRL_OFS, 32'h101);
    wait_obs(0, 1'b1, 4);
    cyc(1);
    apb(1'b0, PLLSW_ISTAT_OFS, 32'h0);
    chk32(q & 32'h1, 32'h1);
    chk1(irq, 1'b0);
    wr(PLLSW_IMASK_OFS, 32'h1);
    cyc(2);
    chk1(irq, 1'b1);
    wr(PLLSW_ISTAT_OFS, 32'h1);
    cyc(2);
    chk1(irq, 1'b0);
    @(posedge clk_i) swreq <= 1'b0;
    wait_obs(0, 1'b0, 4);
    @(posedge clk_i) run_p <= 1'b0;
    cyc(2);
    chk1(pf, 1'b0);
    wait_obs(1, 1'b1, TMO + 10);
    @(posedge clk_i) run_p <= 1'b1;
    wait_obs(1, 1'b0, 2 * HALF + 4);
    @(posedge clk_i) run_s <= 1'b0;
    wait_obs(2, 1'b1, TMO + 10);
    @(posedge clk_i) run_s <= 1'b1;
    wait_obs(2, 1'b0, 2 * HALF + 4);
    wr(PLLSW_CTRL_OFS, 32'h103);
    cyc(3);
    chk1(act, 1'b0);
    @(posedge clk_i) locked <= 1'b0;
    wait_obs(0, 1'b1, 5);
    @(posedge clk_i) locked <= 1'b1;
    wr(PLLSW_CTRL_OFS, 32'h101);
    wait_obs(0, 1'b0, 4);
    wr(PLLSW_CTRL_OFS, 32'h103);
    @(posedge clk_i) run_p <= 1'b0;
    wait_obs(0, 1'b1, TMO + 12);
    @(posedge clk_i) run_p <= 1'b1;
    wr(PLLSW_CTRL_OFS, 32'h105);
    @(posedge clk_i) swreq <= 1'b1;
    wait_obs(0, 1'b0, 5);
    @(posedge clk_i) locked <= 1'b0;
    wait_obs(0, 1'b1, 5);
    @(posedge clk_i) locked <= 1'b1;
    swreq <= 1'b0;
    wr(PLLSW_CTRL_OFS, 32'h101);
    wait_obs(0, 1'b0, 4);
    seed = lfsr(seed);
    n = 2 + int'(seed[1:0]);
    wr(PLLSW_DELAY_OFS, 32'(n));
    wr(PLLSW_CTRL_OFS, 32'h109);
    @(posedge clk_i) swreq <= 1'b1;
    cyc(4);
    chk1(act, 1'b0);
    wait_obs(0, 1'b1, n * 2 * HALF + 12);
    @(posedge clk_i) swreq <= 1'b0;
    cyc(4);
    chk1(act, 1'b1);
    wait_obs(0, 1'b0, n * 2 * HALF + 12);
    seed = lfsr(seed);
    r1 = 8'h10 + {1'b0, seed[6:0]};
    r2 = {4'h0, seed[11:8]};
    phase_run(8'h01, 1'b1, 8'h01);
    phase_run(r1, 1'b1, 8'h01 + r1);
    phase_run(r2, 1'b0, 8'h01 + r1 - r2);
    complete_run();
  end
endmodule : pll_ref_clock_switchover_tb

// ===== sim/pllsw_ref_src.sv
// Partner model: the two reference clock sources, each able to stop
`timescale 1ns/1ps
module pllsw_ref_src #(
  parameter int HALF = 3
)(
  input  wire logic clk_i,
  input  wire logic run_p_i,
  input  wire logic run_s_i,
  output logic      primary_ref_clock_o = 1'b0,
  output logic      secondary_ref_clock_o = 1'b0
);
  int cnt = 0;
  // Both sources run well below half the sampling clock so no edge is missed
  // A stopped source freezes at its level, as a dead oscillator would
  always @(posedge clk_i)
  begin
    cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    if (cnt == HALF - 1 && run_p_i)
      primary_ref_clock_o <= ~primary_ref_clock_o;
    if (cnt == 0 && run_s_i)
      secondary_ref_clock_o <= ~secondary_ref_clock_o;
  end
endmodule : pllsw_ref_src
